// ### src/sls_lamp_map.svh
`ifndef SLS_LAMP_MAP_SVH
`define SLS_LAMP_MAP_SVH

// Register byte offsets
`define SLS_CTRL_OFFSET       32'h0000_0000
`define SLS_STATUS_OFFSET     32'h0000_0004

// Control register fields
`define SLS_CTRL_POWERED      0
`define SLS_CTRL_APP_RUN      1
`define SLS_CTRL_FIRMWARE     2
`define SLS_CTRL_CRITICAL     3
`define SLS_CTRL_STANDARD     4
`define SLS_CTRL_HISTORIC     5
`define SLS_CTRL_USER_LAMP    6
`define SLS_CTRL_WIDTH        7
`define SLS_CTRL_RESET        7'h05

// Status register fields
`define SLS_STAT_POWER_LAMP   0
`define SLS_STAT_FAULT_LAMP   1
`define SLS_STAT_USER_LAMP    2
`define SLS_STAT_PATTERN_LO   3
`define SLS_STAT_HOLDING      5
`define SLS_STAT_BULB         6

// Timing
`define SLS_CLK_PERIOD_NS     10
`define SLS_TICK_NS           1000000
`define SLS_TICK_CYCLES       (`SLS_TICK_NS / `SLS_CLK_PERIOD_NS)
`define SLS_POWER_ON_MS       100
`define SLS_POWER_OFF_MS      100
`define SLS_CRIT_ON_MS        200
`define SLS_CRIT_OFF_MS       200
`define SLS_HIST_ON_MS        100
`define SLS_HIST_OFF_MS       1500
`define SLS_HOLD_MS           3000
`define SLS_BULB_MS           500

`define SLS_PHASE_WIDTH       11
`define SLS_HOLD_WIDTH        12
`define SLS_BULB_WIDTH        10

`endif

// ### src/sls_pkg.sv
package sls_pkg;

    typedef enum logic [1:0] {
        FPAT_OFF,
        FPAT_HIST,
        FPAT_STEADY,
        FPAT_CRIT
    } sls_fpat_type;

endpackage

// ### src/sls_blink_if.sv
`timescale 1ns/1ns
interface sls_blink_if;
    logic       ms_tick;
    logic [2:0] lit;

    modport gen (output ms_tick, output lit);
    modport use_side (input ms_tick, input lit);
endinterface

// ### src/sls_blink_gen.sv
`timescale 1ns/1ns
`include "sls_lamp_map.svh"

// Free-running millisecond tick and three blink cadences:
// lit[0] power fast flash, lit[1] critical flash, lit[2] historic pulse.
module sls_blink_gen #(
    parameter int TICK_CYCLES = `SLS_TICK_CYCLES
) (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    sls_blink_if.gen   bl
);

    localparam int ON_MS  [3] = '{`SLS_POWER_ON_MS, `SLS_CRIT_ON_MS, `SLS_HIST_ON_MS};
    localparam int PER_MS [3] = '{`SLS_POWER_ON_MS + `SLS_POWER_OFF_MS,
                                  `SLS_CRIT_ON_MS + `SLS_CRIT_OFF_MS,
                                  `SLS_HIST_ON_MS + `SLS_HIST_OFF_MS};

    typedef struct packed {
        logic [31:0]                           tick_cnt;
        logic                                  tick;
        logic [2:0][`SLS_PHASE_WIDTH-1:0]      phase;
        logic [2:0]                            lit;
    } sls_gen_state_type;

    sls_gen_state_type state_r;
    sls_gen_state_type state_nxt;

    always_comb begin
        state_nxt      = state_r;
        state_nxt.tick = 1'b0;
        if (state_r.tick_cnt == 32'(TICK_CYCLES - 1)) begin
            state_nxt.tick_cnt = 32'h0000_0000;
            state_nxt.tick     = 1'b1;
        end else begin
            state_nxt.tick_cnt = state_r.tick_cnt + 32'h0000_0001;
        end
        for (int i = 0; i < 3; i++) begin
            if (state_r.tick) begin
                if (state_r.phase[i] == `SLS_PHASE_WIDTH'(PER_MS[i] - 1)) begin
                    state_nxt.phase[i] = '0;
                end else begin
                    state_nxt.phase[i] = state_r.phase[i] + `SLS_PHASE_WIDTH'(1);
                end
            end
            // Lit during the first part of each period, dark for the rest
            state_nxt.lit[i] = (state_nxt.phase[i] < `SLS_PHASE_WIDTH'(ON_MS[i]));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r       <= '0;
            state_r.lit   <= 3'h7;
        end else begin
            state_r       <= state_nxt;
        end
    end

    assign bl.ms_tick = state_r.tick;
    assign bl.lit     = state_r.lit;

endmodule

// ### src/sls_lamp_top.sv
`timescale 1ns/1ns
`include "sls_lamp_map.svh"

module sls_lamp_top #(
    parameter int TICK_CYCLES = `SLS_TICK_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             power_lamp,
    output logic             fault_lamp_output,
    output logic             user_lamp
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic                          awready;
        logic                          wready;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic [31:0]                   awaddr;
        logic [31:0]                   wdata;
        logic [3:0]                    wstrb;
        logic                          arready;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [31:0]                   rdata;
        logic [`SLS_CTRL_WIDTH-1:0]    ctrl;
        sls_pkg::sls_fpat_type         shown;
        logic [`SLS_HOLD_WIDTH-1:0]    hold_cnt;
        logic                          bulb;
        logic [`SLS_BULB_WIDTH-1:0]    bulb_cnt;
        logic                          power_lamp;
        logic                          fault_lamp;
        logic                          user_lamp;
    } sls_top_state_type;

    sls_top_state_type     state_r;
    sls_top_state_type     state_nxt;
    sls_pkg::sls_fpat_type desired;
    logic [31:0]           status_word;

    sls_blink_if blink ();

    sls_blink_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_blink (
        .aclk    (aclk),
        .aresetn (aresetn),
        .bl      (blink.gen)
    );

    wire logic powered  = state_r.ctrl[`SLS_CTRL_POWERED];
    wire logic app_run  = state_r.ctrl[`SLS_CTRL_APP_RUN];
    wire logic firmware = state_r.ctrl[`SLS_CTRL_FIRMWARE];
    wire logic critical = state_r.ctrl[`SLS_CTRL_CRITICAL];
    wire logic standard = state_r.ctrl[`SLS_CTRL_STANDARD];
    wire logic historic = state_r.ctrl[`SLS_CTRL_HISTORIC];

    // Pattern the present conditions ask for: missing firmware wins outright, the rest most severe first
    always_comb begin
        if (!firmware) begin
            desired = sls_pkg::FPAT_STEADY;
        end else if (critical) begin
            desired = sls_pkg::FPAT_CRIT;
        end else if (standard) begin
            desired = sls_pkg::FPAT_STEADY;
        end else if (historic && !app_run) begin
            desired = sls_pkg::FPAT_HIST;
        end else begin
            desired = sls_pkg::FPAT_OFF;
        end
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SLS_STAT_POWER_LAMP]              = state_r.power_lamp;
        status_word[`SLS_STAT_FAULT_LAMP]              = state_r.fault_lamp;
        status_word[`SLS_STAT_USER_LAMP]               = state_r.user_lamp;
        status_word[`SLS_STAT_PATTERN_LO+1:`SLS_STAT_PATTERN_LO] = state_r.shown;
        status_word[`SLS_STAT_HOLDING]                 = (desired != state_r.shown);
        status_word[`SLS_STAT_BULB]                    = state_r.bulb;
    end

    always_comb begin
        state_nxt = state_r;

        // Write channel: address and data taken in either order, answered once both are in
        if (s_axi_awvalid && state_r.awready) begin
            state_nxt.awaddr  = s_axi_awaddr;
            state_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && state_r.wready) begin
            state_nxt.wdata  = s_axi_wdata;
            state_nxt.wstrb  = s_axi_wstrb;
            state_nxt.wready = 1'b0;
        end
        if (!state_r.awready && !state_r.wready && !state_r.bvalid) begin
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp  = RESP_OKAY;
            if (state_r.awaddr[31:2] == 30'(`SLS_CTRL_OFFSET >> 2)) begin
                if (state_r.wstrb[0]) begin
                    state_nxt.ctrl = state_r.wdata[`SLS_CTRL_WIDTH-1:0];
                end
            end else if (state_r.awaddr[31:2] != 30'(`SLS_STATUS_OFFSET >> 2)) begin
                state_nxt.bresp = RESP_SLVERR;
            end
        end
        if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid  = 1'b0;
            state_nxt.awready = 1'b1;
            state_nxt.wready  = 1'b1;
        end

        // Read channel: one outstanding read, data one cycle after the address
        if (s_axi_arvalid && state_r.arready) begin
            state_nxt.arready = 1'b0;
            state_nxt.rvalid  = 1'b1;
            state_nxt.rresp   = RESP_OKAY;
            if (s_axi_araddr[31:2] == 30'(`SLS_CTRL_OFFSET >> 2)) begin
                state_nxt.rdata = {{(32-`SLS_CTRL_WIDTH){1'b0}}, state_r.ctrl};
            end else if (s_axi_araddr[31:2] == 30'(`SLS_STATUS_OFFSET >> 2)) begin
                state_nxt.rdata = status_word;
            end else begin
                state_nxt.rdata = 32'h0000_0000;
                state_nxt.rresp = RESP_SLVERR;
            end
        end
        if (state_r.rvalid && s_axi_rready) begin
            state_nxt.rvalid  = 1'b0;
            state_nxt.arready = 1'b1;
        end

        // Bulb check runs once from reset
        if (state_r.bulb && blink.ms_tick) begin
            if (state_r.bulb_cnt == `SLS_BULB_WIDTH'(`SLS_BULB_MS - 1)) begin
                state_nxt.bulb = 1'b0;
            end else begin
                state_nxt.bulb_cnt = state_r.bulb_cnt + `SLS_BULB_WIDTH'(1);
            end
        end

        // A more severe pattern shows at once; a milder one waits out the hold
        if (desired == state_r.shown) begin
            state_nxt.hold_cnt = '0;
        end else if (desired > state_r.shown) begin
            state_nxt.shown    = desired;
            state_nxt.hold_cnt = '0;
        end else if (blink.ms_tick) begin
            if (state_r.hold_cnt == `SLS_HOLD_WIDTH'(`SLS_HOLD_MS - 1)) begin
                state_nxt.shown    = desired;
                state_nxt.hold_cnt = '0;
            end else begin
                state_nxt.hold_cnt = state_r.hold_cnt + `SLS_HOLD_WIDTH'(1);
            end
        end

        // Lamp drives
        if (!firmware || !powered) begin
            state_nxt.power_lamp = 1'b0;
        end else if (app_run) begin
            state_nxt.power_lamp = blink.lit[0];
        end else begin
            state_nxt.power_lamp = 1'b1;
        end

        if (state_r.bulb) begin
            state_nxt.fault_lamp = 1'b1;
        end else begin
            unique case (state_r.shown)
                sls_pkg::FPAT_OFF:    state_nxt.fault_lamp = 1'b0;
                sls_pkg::FPAT_HIST:   state_nxt.fault_lamp = blink.lit[2];
                sls_pkg::FPAT_STEADY: state_nxt.fault_lamp = 1'b1;
                sls_pkg::FPAT_CRIT:   state_nxt.fault_lamp = blink.lit[1];
            endcase
        end

        // No cadence of its own: a straight copy of the request bit
        state_nxt.user_lamp = state_r.ctrl[`SLS_CTRL_USER_LAMP];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r         <= '0;
            state_r.awready <= 1'b1;
            state_r.wready  <= 1'b1;
            state_r.arready <= 1'b1;
            state_r.ctrl    <= `SLS_CTRL_RESET;
            state_r.shown   <= sls_pkg::FPAT_OFF;
            state_r.bulb    <= 1'b1;
        end else begin
            state_r         <= state_nxt;
        end
    end

    assign s_axi_awready     = state_r.awready;
    assign s_axi_wready      = state_r.wready;
    assign s_axi_bvalid      = state_r.bvalid;
    assign s_axi_bresp       = state_r.bresp;
    assign s_axi_arready     = state_r.arready;
    assign s_axi_rvalid      = state_r.rvalid;
    assign s_axi_rresp       = state_r.rresp;
    assign s_axi_rdata       = state_r.rdata;
    assign power_lamp        = state_r.power_lamp;
    assign fault_lamp_output = state_r.fault_lamp;
    assign user_lamp         = state_r.user_lamp;

endmodule

// ### testbench/sls_lamp_assertions.sv
`timescale 1ns/1ns
module sls_lamp_assertions #(
    parameter int TICK_CYCLES = 100000
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        power_lamp,
    input wire logic        fault_lamp_output,
    input wire logic        user_lamp
);
    localparam int FL   = 100 * TICK_CYCLES;
    localparam int CR   = 200 * TICK_CYCLES;
    localparam int HON  = 100 * TICK_CYCLES;
    localparam int HOFF = 1500 * TICK_CYCLES;
    localparam int HOLD = 3000 * TICK_CYCLES;
    logic [6:0] sh_r;
    logic [6:0] old_r;
    logic       pseen_r;
    logic       fseen_r;
    int         quiet_r;
    int         prun_r;
    int         frun_r;
    wire take_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ctrl_w = take_w && s_axi_awaddr[31:2] == 30'h0000_0000 && s_axi_wstrb[0];
    wire pw = sh_r[0];
    wire app = sh_r[1];
    wire fw = sh_r[2];
    wire cr = sh_r[3];
    wire sd = sh_r[4];
    wire hs = sh_r[5];
    // Shadow of the control word; quiet_r counts cycles since it was last written
    always_ff @(posedge aclk) begin
        pseen_r <= power_lamp;
        fseen_r <= fault_lamp_output;
        prun_r  <= (power_lamp != pseen_r) ? 1 : prun_r + 1;
        frun_r  <= (fault_lamp_output != fseen_r) ? 1 : frun_r + 1;
        if (!aresetn) begin
            sh_r    <= 7'h05;
            old_r   <= 7'h05;
            quiet_r <= 0;
        end else if (ctrl_w) begin
            old_r   <= sh_r;
            sh_r    <= s_axi_wdata[6:0];
            quiet_r <= 0;
        end else if (quiet_r < 1000000) begin
            quiet_r <= quiet_r + 1;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence bulb_on;
        fault_lamp_output [*8];
    endsequence
    chk_bulb_check: assert property ($rose(aresetn) |-> ##3 bulb_on)
        else $error("fault lamp missed bulb check");
    chk_power_dark: assert property (quiet_r >= 4 && !(pw && fw) |-> !power_lamp)
        else $error("power lamp lit while unpowered or without firmware");
    chk_power_steady: assert property (quiet_r >= 4 && pw && fw && !app |-> power_lamp)
        else $error("power lamp not steady while idle");
    chk_power_flash: assert property (quiet_r > 3 * FL && pw && fw && app && power_lamp != pseen_r
        |-> prun_r == FL) else $error("power flash stretch wrong");
    chk_crit_flash: assert property (quiet_r > 3 * CR && cr && fault_lamp_output != fseen_r
        |-> frun_r == CR) else $error("critical flash stretch wrong");
    chk_steady_fault: assert property (quiet_r > HOLD + 20 && !cr && (sd || !fw) |-> fault_lamp_output)
        else $error("fault lamp not steady");
    chk_dark_fault: assert property (quiet_r > HOLD + 20 && !cr && !sd && fw && (app || !hs)
        |-> !fault_lamp_output) else $error("fault lamp lit without fault");
    chk_hist_pulse: assert property (quiet_r > 2 * (HON + HOFF) && !cr && !sd && fw && hs && !app
        && !old_r[3] && !old_r[4] && old_r[2] && fault_lamp_output != fseen_r
        |-> frun_r == (fault_lamp_output ? HOFF : HON)) else $error("historic pulse stretch wrong");
    chk_fault_hold: assert property (quiet_r >= 4 && quiet_r < HOLD - 20 && old_r[4] && !old_r[3]
        && old_r[2] && !cr && !sd && fw && !hs |-> fault_lamp_output) else $error("fault lamp hold too short");
    chk_user_follow: assert property (quiet_r >= 4 |-> user_lamp == sh_r[6])
        else $error("user lamp does not follow request");
    chk_write_answer: assert property (take_w |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule
bind sls_lamp_top sls_lamp_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .power_lamp, .fault_lamp_output, .user_lamp
);

// ### testbench/sls_lamp_panel.sv
`timescale 1ns/1ns
// Operator view of one lamp: lengths of its last completed lit and dark stretch
module sls_lamp_panel (
    input  wire logic aclk,
    input  wire logic lamp,
    output int        lit_len,
    output int        dark_len
);
    logic seen_r = 1'b0;
    int   run_r  = 0;
    always @(posedge aclk) begin
        if (lamp !== seen_r) begin
            if (seen_r)
                lit_len <= run_r;
            else
                dark_len <= run_r;
            run_r <= 1;
        end else begin
            run_r <= run_r + 1;
        end
        seen_r <= lamp;
    end
endmodule

// ### testbench/sls_lamp_top_bench.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module sls_lamp_top_bench;
    localparam int T = 4;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rv;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, power_lamp, fault_lamp_output, user_lamp;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, br, rr;
    int          fails = 0, n_compared = 0, cyc = 0, plit, pdark, flit, fdark;
    sls_lamp_top #(.TICK_CYCLES(T)) dut_u (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_lamp, .fault_lamp_output, .user_lamp
    );
    sls_lamp_panel pan_p (.aclk, .lamp(power_lamp), .lit_len(plit), .dark_len(pdark));
    sls_lamp_panel pan_f (.aclk, .lamp(fault_lamp_output), .lit_len(flit), .dark_len(fdark));
    initial forever #5 aclk = ~aclk;
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Whole run needs about 65000 cycles; anything past this is a hang
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            stop_test;
        end
    end
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        // Each channel is released at its own handshake edge, in whatever order the slave takes them
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        br = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic t_reset;
        rd(32'h0000_0000);
        `CHK("ctrl reset", 32'h0000_0005, rv)
        rd(32'h0000_0004);
        `CHK("status bulb", 1'b1, rv[6])
        `CHK("status power", 1'b1, rv[0])
        pause(2);
        `CHK("bulb lamp", 1'b1, fault_lamp_output)
        pause(2500);
        `CHK("fault after bulb", 1'b0, fault_lamp_output)
        `CHK("power idle", 1'b1, power_lamp)
        $display("t_reset done");
    endtask
    task automatic t_user;
        wr(32'h0000_0000, 32'h0000_0045);
        pause(4);
        `CHK("user on", 1'b1, user_lamp)
        wr(32'h0000_0000, 32'h0000_0005);
        pause(4);
        `CHK("user off", 1'b0, user_lamp)
        wr(32'h0000_0004, 32'h0000_0045);
        `CHK("status write resp", 2'h0, br)
        s_axi_wstrb <= 4'he;
        wr(32'h0000_0000, 32'h0000_0045);
        s_axi_wstrb <= 4'hf;
        wr(32'h0000_0008, 32'h0000_0045);
        `CHK("bad write resp", 2'h2, br)
        rd(32'h0000_0008);
        `CHK("bad read resp", 2'h2, rr)
        pause(4);
        `CHK("user after bad write", 1'b0, user_lamp)
        $display("t_user done");
    endtask
    task automatic t_app;
        wr(32'h0000_0000, 32'h0000_0007);
        pause(1700);
        `CHK("power lit len", 100 * T, plit)
        `CHK("power dark len", 100 * T, pdark)
        $display("t_app done");
    endtask
    task automatic t_crit;
        wr(32'h0000_0000, 32'h0000_001d);
        pause(3300);
        `CHK("crit lit len", 200 * T, flit)
        `CHK("crit dark len", 200 * T, fdark)
        wr(32'h0000_0000, 32'h0000_0015);
        pause(12500);
        `CHK("standard steady", 1'b1, fault_lamp_output)
        rd(32'h0000_0004);
        `CHK("pattern steady", 2'h2, rv[4:3])
        wr(32'h0000_0000, 32'h0000_0005);
        pause(6000);
        `CHK("hold lit", 1'b1, fault_lamp_output)
        rd(32'h0000_0004);
        `CHK("status holding", 1'b1, rv[5])
        pause(6500);
        `CHK("after hold dark", 1'b0, fault_lamp_output)
        $display("t_crit done");
    endtask
    task automatic t_hist;
        wr(32'h0000_0000, 32'h0000_0025);
        pause(20000);
        `CHK("hist lit len", 100 * T, flit)
        `CHK("hist dark len", 1500 * T, fdark)
        rd(32'h0000_0004);
        `CHK("pattern hist", 2'h1, rv[4:3])
        wr(32'h0000_0000, 32'h0000_0027);
        pause(12500);
        `CHK("hist hidden by app", 1'b0, fault_lamp_output)
        wr(32'h0000_0000, 32'h0000_0001);
        pause(10);
        `CHK("no fw power", 1'b0, power_lamp)
        `CHK("no fw fault", 1'b1, fault_lamp_output)
        $display("t_hist done");
    endtask
    // Second power-up in mid-run: ctrl back to its reset value and a fresh bulb check
    task automatic t_rerun;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(32'h0000_0000);
        `CHK("ctrl after rerun", 32'h0000_0005, rv)
        rd(32'h0000_0004);
        `CHK("rerun bulb", 1'b1, rv[6])
        pause(2);
        `CHK("rerun power idle", 1'b1, power_lamp)
        $display("t_rerun done");
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_user;
        t_app;
        t_crit;
        t_hist;
        t_rerun;
        stop_test;
    end
endmodule
